// File: hw/asrc_pkg.sv
/*
  Constants shared by the control register bank of the audio transceiver:
  register indices, field positions, writable-bit masks and reset values.
  Assumes a single 50 MHz control clock; nothing here is timing critical.
*/
`default_nettype none

package asrc_pkg;

  // ----------------------------------------------------------------------
  // Register indices (seven-bit address space)
  // ----------------------------------------------------------------------
  localparam logic [6:0] ADDR_MISC_CONTROL_ONE   = 7'h01;
  localparam logic [6:0] ADDR_MISC_CONTROL_TWO   = 7'h02;
  localparam logic [6:0] ADDR_SERIAL_OUT_FORMAT  = 7'h06;
  localparam logic [6:0] ADDR_EVENT_STATUS_ONE   = 7'h07;
  localparam logic [6:0] ADDR_EVENT_STATUS_TWO   = 7'h08;
  localparam logic [6:0] ADDR_EVENT_MASK_ONE     = 7'h09;
  localparam logic [6:0] ADDR_EVENT_MODE_ONE_UP  = 7'h0a;
  localparam logic [6:0] ADDR_EVENT_MODE_ONE_LO  = 7'h0b;
  localparam logic [6:0] ADDR_EVENT_MASK_TWO     = 7'h0c;
  localparam logic [6:0] ADDR_EVENT_MODE_TWO_UP  = 7'h0d;
  localparam logic [6:0] ADDR_EVENT_MODE_TWO_LO  = 7'h0e;
  localparam logic [6:0] ADDR_RECEIVED_SUMMARY   = 7'h0f;
  localparam logic [6:0] ADDR_RECEIVE_ERRORS     = 7'h10;
  localparam logic [6:0] ADDR_USER_BUFFER_CTRL   = 7'h13;
  localparam logic [6:0] ADDR_SUBCODE_FIRST      = 7'h14;
  localparam logic [6:0] ADDR_SUBCODE_LAST       = 7'h1d;
  localparam logic [6:0] ADDR_RATE_RATIO         = 7'h1e;
  localparam logic [6:0] ADDR_BUFFER_FIRST       = 7'h20;
  localparam logic [6:0] ADDR_BUFFER_LAST        = 7'h37;
  localparam logic [6:0] ADDR_IDENTITY_VERSION   = 7'h7f;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int CTL_COUNT    = 20;   // Control slots 0..19
  localparam int BUFFER_BYTES = 24;   // Status or user data buffer
  localparam int SUBCODE_BYTES = 10;  // Subcode bytes
  localparam int EVENT_COUNT  = 16;   // Two event registers, eight bits each

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] POINTER_RESET = 8'h01;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------------
  // Pointer fields
  // ----------------------------------------------------------------------
  localparam int PTR_AUTO_ADVANCE_BIT = 7;

  // ----------------------------------------------------------------------
  // Field positions in misc_control_one
  // ----------------------------------------------------------------------
  localparam int C1_CLOCK_SUBST   = 7;
  localparam int C1_VALIDITY      = 6;
  localparam int C1_SERIAL_MUTE   = 5;
  localparam int C1_LINE_TX_MUTE  = 4;
  localparam int C1_DITHER_OFF    = 3;
  localparam int C1_ALERT_SEL_HI  = 2;
  localparam int C1_ALERT_SEL_LO  = 1;
  localparam int C1_BLOCK_SYNC    = 0;

  // ----------------------------------------------------------------------
  // Field positions in misc_control_two
  // ----------------------------------------------------------------------
  localparam int C2_LEN_FROM_STATUS = 7;
  localparam int C2_POLICY_HI       = 6;
  localparam int C2_POLICY_LO       = 5;
  localparam int C2_CLOCK_RATIO     = 4;
  localparam int C2_RX_MONO         = 3;
  localparam int C2_TX_MONO         = 2;
  localparam int C2_MONO_STATUS_SEL = 1;
  localparam int C2_MONO_CHAN_SEL   = 0;

  // ----------------------------------------------------------------------
  // Alert pin drive codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] ALERT_ACTIVE_HIGH = 2'h0;
  localparam logic [1:0] ALERT_ACTIVE_LOW  = 2'h1;
  localparam logic [1:0] ALERT_OPEN_DRAIN  = 2'h2;

  // ----------------------------------------------------------------------
  // Event mode codes {upper, lower}
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_RISING  = 2'h0;
  localparam logic [1:0] MODE_FALLING = 2'h1;
  localparam logic [1:0] MODE_LEVEL   = 2'h2;

  // ----------------------------------------------------------------------
  // Writable bits per control slot; zero bits read back as zero
  // ----------------------------------------------------------------------
  localparam logic [7:0] WMASK_FULL    = 8'hff;
  localparam logic [7:0] WMASK_CLOCK   = 8'h7f;
  localparam logic [7:0] WMASK_SIX     = 8'h3f;
  localparam logic [7:0] WMASK_SEVEN   = 8'h7f;
  localparam logic [7:0] WMASK_USER    = 8'h1f;
  localparam logic [6:0] ADDR_CLOCK_ROUTING = 7'h04;
  localparam logic [6:0] ADDR_ERROR_MASK    = 7'h11;
  localparam logic [6:0] ADDR_STATUS_BUF_CTRL = 7'h12;

endpackage : asrc_pkg

`default_nettype wire

// File: hw/asrc_reg_bank.sv
/*
  Control register bank and alert-pin logic of the stereo audio transceiver.
  Holds the address pointer, the control, mask and mode registers, the
  event status registers, the status/user data buffer and the identity
  register. Assumes the serial control-port framer upstream delivers one
  strobe per byte on the same clock, and that event sources are synchronous.
*/
// Behaviour
// - Alert drive code: high, low, open-drain
// - Sources 0-13 have their own mask; 14-15 stay masked
// - Per-source mode from upper and lower bits
// - Pointer: advance bit 7, address 6:0, resets 01
// - Advance bit clear keeps pointer fixed
// - Map: control 1-19, subcode, ratio, buffer
// - Address 127 returns identity and version
// - Substitute output clock when receiver idle
// - Validity bit follows validity control
// - Serial output mute bit
// - Line transmitter mute bit
// - Dither added unless disabled
// - Block sync pin direction bit
// - Word length from status when set
// - Receiver error sample policy code
// - Recovered clock ratio 256 or 128
// - Receiver mono duplicates subframes
// - Transmitter mono packs one channel
// - Mono status select shares one status
// - Mono channel select picks left/right
// - Auto advance bumps pointer per byte
// - Status read clears, level stays, masked zero
`default_nettype none

module asrc_reg_bank #(
  parameter logic [3:0] IDENTITY_CODE = 4'h5,  // Arbitrary value
  parameter logic [3:0] VERSION_CODE  = 4'h1   // Arbitrary value
) (
  // Clock, reset, enable
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  input  wire logic        ce_in,
  // Byte strobes from the control-port framer
  input  wire logic        ptr_wr_in,
  input  wire logic        data_wr_in,
  input  wire logic        data_rd_in,
  input  wire logic [7:0]  wr_byte_in,
  output logic      [7:0]  rd_byte_out,
  output logic             rd_valid_out,
  output logic      [7:0]  pointer_out,
  // Device status inputs
  input  wire logic [15:0] event_src_in,
  input  wire logic        rx_no_input_in,
  input  wire logic [7:0]  received_summary_in,
  input  wire logic [7:0]  receive_errors_in,
  input  wire logic [79:0] subcode_in,
  input  wire logic [7:0]  rate_ratio_in,
  // Alert pin
  input  wire logic        alert_pin_in,
  output logic             alert_pin_out,
  output logic             alert_pin_oe_out,
  // Control outputs
  output logic             recovered_master_clock_pin_from_output_master_clock_out,
  output logic             validity_level_out,
  output logic             serial_out_mute_out,
  output logic             line_tx_mute_out,
  output logic             dither_enable_out,
  output logic             block_sync_direction_out,
  output logic             length_from_status_out,
  output logic      [1:0]  error_sample_policy_out,
  output logic             recovered_clock_ratio_out,
  output logic             receiver_mono_out,
  output logic             transmitter_mono_out,
  output logic             tx_sub_a_right_out,
  output logic             tx_sub_b_right_out,
  output logic             tx_status_a_right_out,
  output logic             tx_status_b_right_out,
  output logic      [7:0]  data_routing_out,
  output logic      [7:0]  clock_routing_out,
  output logic      [7:0]  serial_input_format_out,
  output logic      [7:0]  serial_output_format_out,
  output logic      [7:0]  receive_error_mask_out,
  output logic      [7:0]  status_buffer_control_out,
  output logic      [7:0]  user_buffer_control_out
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [7:0]  pointer;                               // Address pointer
  logic [7:0]  ctl_reg [asrc_pkg::CTL_COUNT];         // Control slots
  logic [7:0]  buf_mem [asrc_pkg::BUFFER_BYTES];      // Data buffer
  logic [15:0] event_status;                          // Sticky events
  logic [15:0] src_prev;                              // Last source levels
  logic [15:0] next_event_status;                     // Next status
  logic [15:0] event_hit;                             // Events this cycle
  logic [15:0] event_clear;                           // Read-clear request
  logic [15:0] event_mask;                            // Mask, both regs
  logic [15:0] event_mode_up;                         // Mode upper bits
  logic [15:0] event_mode_lo;                         // Mode lower bits
  logic [7:0]  next_rd_byte;                          // Read mux result
  logic [7:0]  wr_mask;                               // Writable bits
  logic        alert_active;                          // Any unmasked event
  logic [6:0]  addr;                                  // Register address
  logic        take_rd;                               // Read accepted
  logic        take_wr;                               // Write accepted

  assign addr    = pointer[6:0];
  assign take_wr = ce_in && data_wr_in && !ptr_wr_in;
  // Write wins a collision; the read is dropped
  assign take_rd = ce_in && data_rd_in && !ptr_wr_in && !data_wr_in;

  // ----------------------------------------------------------------------
  // Event vectors gathered from the mask and mode slots
  // ----------------------------------------------------------------------
  // Upper two bits of the second group do not exist, so they stay zero
  assign event_mask    = {ctl_reg[12] & asrc_pkg::WMASK_SIX, ctl_reg[9]};
  assign event_mode_up = {ctl_reg[13] & asrc_pkg::WMASK_SIX, ctl_reg[10]};
  assign event_mode_lo = {ctl_reg[14] & asrc_pkg::WMASK_SIX, ctl_reg[11]};

  // ----------------------------------------------------------------------
  // Address pointer
  // ----------------------------------------------------------------------
  // Pointer load, then per-byte advance when enabled
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      pointer <= asrc_pkg::POINTER_RESET;
    end
    else if (ce_in && ptr_wr_in)
    begin
      pointer <= wr_byte_in;
    end
    else if ((take_wr || take_rd) && pointer[asrc_pkg::PTR_AUTO_ADVANCE_BIT])
    begin
      // Seven-bit address wraps from 127 to 0; the advance bit is kept
      pointer <= {pointer[7], 7'(addr + 7'h01)};
    end
    // Advance bit clear: the pointer holds between bytes
  end

  // ----------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------
  // Bits that read as zero cannot be set
  always_comb
  begin
    if (addr == asrc_pkg::ADDR_CLOCK_ROUTING)
    begin
      wr_mask = asrc_pkg::WMASK_CLOCK;
    end
    else if (addr == asrc_pkg::ADDR_EVENT_MASK_TWO || addr == asrc_pkg::ADDR_EVENT_MODE_TWO_UP
             || addr == asrc_pkg::ADDR_EVENT_MODE_TWO_LO
             || addr == asrc_pkg::ADDR_STATUS_BUF_CTRL)
    begin
      wr_mask = asrc_pkg::WMASK_SIX;
    end
    else if (addr == asrc_pkg::ADDR_ERROR_MASK)
    begin
      wr_mask = asrc_pkg::WMASK_SEVEN;
    end
    else if (addr == asrc_pkg::ADDR_USER_BUFFER_CTRL)
    begin
      wr_mask = asrc_pkg::WMASK_USER;
    end
    else
    begin
      wr_mask = asrc_pkg::WMASK_FULL;
    end
  end

  // Control slots; status, summary and error slots are read-only
  genvar gi;
  generate
    for (gi = 0; gi < asrc_pkg::CTL_COUNT; gi++)
    begin : g_ctl
      always_ff @(posedge mclk_in)
      begin
        if (!rstn_in)
        begin
          ctl_reg[gi] <= asrc_pkg::CONTROL_RESET;
        end
        else if (take_wr && addr == 7'(gi) && gi != 0 && gi != 7 && gi != 8
                 && gi != 15 && gi != 16)
        begin
          // Reserved slot 0 is ignored, host must not write it
          ctl_reg[gi] <= wr_byte_in & wr_mask;
        end
      end
    end
  endgenerate

  // Data buffer bytes at 32..55
  generate
    for (gi = 0; gi < asrc_pkg::BUFFER_BYTES; gi++)
    begin : g_buf
      always_ff @(posedge mclk_in)
      begin
        if (!rstn_in)
        begin
          buf_mem[gi] <= asrc_pkg::CONTROL_RESET;
        end
        else if (take_wr && addr == 7'(gi + 32))
        begin
          buf_mem[gi] <= wr_byte_in;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Event detection per source
  // ----------------------------------------------------------------------
  // Each source: edge or level per its mode pair, gated by its mask
  generate
    for (gi = 0; gi < asrc_pkg::EVENT_COUNT; gi++)
    begin : g_evt
      always_comb
      begin
        case ({event_mode_up[gi], event_mode_lo[gi]})
          asrc_pkg::MODE_RISING:
            event_hit[gi] = event_src_in[gi] && !src_prev[gi];
          asrc_pkg::MODE_FALLING:
            event_hit[gi] = !event_src_in[gi] && src_prev[gi];
          asrc_pkg::MODE_LEVEL:
            event_hit[gi] = event_src_in[gi];
          // Reserved pair never raises an event
          default:
            event_hit[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  // Reading a status slot requests a clear of its bits
  always_comb
  begin
    event_clear = 16'h0000;
    if (take_rd && addr == asrc_pkg::ADDR_EVENT_STATUS_ONE)
    begin
      event_clear[7:0] = 8'hff;
    end
    else if (take_rd && addr == asrc_pkg::ADDR_EVENT_STATUS_TWO)
    begin
      event_clear[15:8] = 8'hff;
    end
  end

  // Set wins over the clear, so a level source still true stays set
  assign next_event_status = ((event_status & ~event_clear) | event_hit) & event_mask;
  assign alert_active      = |next_event_status;

  // Sticky status and source history
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      event_status <= 16'h0000;
      src_prev     <= 16'h0000;
    end
    else if (ce_in)
    begin
      // Masked bits are dropped, so they always read zero
      event_status <= next_event_status;
      src_prev     <= event_src_in;
    end
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  // Reserved addresses read zero
  always_comb
  begin
    if (addr == asrc_pkg::ADDR_EVENT_STATUS_ONE)
    begin
      next_rd_byte = event_status[7:0] & event_mask[7:0];
    end
    else if (addr == asrc_pkg::ADDR_EVENT_STATUS_TWO)
    begin
      next_rd_byte = event_status[15:8] & event_mask[15:8];
    end
    else if (addr == asrc_pkg::ADDR_RECEIVED_SUMMARY)
    begin
      next_rd_byte = received_summary_in;
    end
    else if (addr == asrc_pkg::ADDR_RECEIVE_ERRORS)
    begin
      next_rd_byte = receive_errors_in & asrc_pkg::WMASK_SEVEN;
    end
    else if (addr != 7'h00 && addr <= asrc_pkg::ADDR_USER_BUFFER_CTRL)
    begin
      next_rd_byte = ctl_reg[5'(addr)];
    end
    else if (addr >= asrc_pkg::ADDR_SUBCODE_FIRST && addr <= asrc_pkg::ADDR_SUBCODE_LAST)
    begin
      next_rd_byte = subcode_in[8 * (addr - asrc_pkg::ADDR_SUBCODE_FIRST) +: 8];
    end
    else if (addr == asrc_pkg::ADDR_RATE_RATIO)
    begin
      next_rd_byte = rate_ratio_in;
    end
    else if (addr >= asrc_pkg::ADDR_BUFFER_FIRST && addr <= asrc_pkg::ADDR_BUFFER_LAST)
    begin
      next_rd_byte = buf_mem[5'(addr - asrc_pkg::ADDR_BUFFER_FIRST)];
    end
    else if (addr == asrc_pkg::ADDR_IDENTITY_VERSION)
    begin
      next_rd_byte = {IDENTITY_CODE, VERSION_CODE};
    end
    else
    begin
      next_rd_byte = asrc_pkg::READ_UNMAPPED;
    end
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      rd_byte_out  <= 8'h00;
      rd_valid_out <= 1'b0;
    end
    else if (ce_in)
    begin
      rd_valid_out <= take_rd;
      if (take_rd)
      begin
        rd_byte_out <= next_rd_byte;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Alert pin
  // ----------------------------------------------------------------------
  // Driven from the next status so the pin follows the sticky bits exactly
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      alert_pin_out    <= 1'b0;
      alert_pin_oe_out <= 1'b1;
    end
    else if (ce_in)
    begin
      case (ctl_reg[1][asrc_pkg::C1_ALERT_SEL_HI:asrc_pkg::C1_ALERT_SEL_LO])
        asrc_pkg::ALERT_ACTIVE_HIGH:
        begin
          alert_pin_out    <= alert_active;
          alert_pin_oe_out <= 1'b1;
        end
        asrc_pkg::ALERT_ACTIVE_LOW:
        begin
          alert_pin_out    <= !alert_active;
          alert_pin_oe_out <= 1'b1;
        end
        asrc_pkg::ALERT_OPEN_DRAIN:
        begin
          // Only pulls low; an external pull-up gives the high level
          alert_pin_out    <= 1'b0;
          alert_pin_oe_out <= alert_active;
        end
        // Reserved code releases the pin rather than guess a level
        default:
        begin
          alert_pin_out    <= 1'b0;
          alert_pin_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Derived datapath controls
  // ----------------------------------------------------------------------
  // Clock substitution and transmitter slot selection
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      recovered_master_clock_pin_from_output_master_clock_out    <= 1'b0;
      dither_enable_out     <= 1'b1;
      tx_sub_a_right_out    <= 1'b0;
      tx_sub_b_right_out    <= 1'b1;
      tx_status_a_right_out <= 1'b0;
      tx_status_b_right_out <= 1'b1;
    end
    else if (ce_in)
    begin
      recovered_master_clock_pin_from_output_master_clock_out <= ctl_reg[1][asrc_pkg::C1_CLOCK_SUBST] && rx_no_input_in;
      dither_enable_out  <= !ctl_reg[1][asrc_pkg::C1_DITHER_OFF];
      if (ctl_reg[2][asrc_pkg::C2_TX_MONO])
      begin
        // Both subframes carry the selected channel
        tx_sub_a_right_out <= ctl_reg[2][asrc_pkg::C2_MONO_CHAN_SEL];
        tx_sub_b_right_out <= ctl_reg[2][asrc_pkg::C2_MONO_CHAN_SEL];
      end
      else
      begin
        tx_sub_a_right_out <= 1'b0;
        tx_sub_b_right_out <= 1'b1;
      end
      if (ctl_reg[2][asrc_pkg::C2_MONO_STATUS_SEL])
      begin
        tx_status_a_right_out <= ctl_reg[2][asrc_pkg::C2_MONO_CHAN_SEL];
        tx_status_b_right_out <= ctl_reg[2][asrc_pkg::C2_MONO_CHAN_SEL];
      end
      else
      begin
        tx_status_a_right_out <= 1'b0;
        tx_status_b_right_out <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Plain control bits straight from their flops
  // ----------------------------------------------------------------------
  assign pointer_out               = pointer;
  assign validity_level_out        = ctl_reg[1][asrc_pkg::C1_VALIDITY];
  assign serial_out_mute_out       = ctl_reg[1][asrc_pkg::C1_SERIAL_MUTE];
  assign line_tx_mute_out          = ctl_reg[1][asrc_pkg::C1_LINE_TX_MUTE];
  assign block_sync_direction_out  = ctl_reg[1][asrc_pkg::C1_BLOCK_SYNC];
  assign length_from_status_out    = ctl_reg[2][asrc_pkg::C2_LEN_FROM_STATUS];
  assign error_sample_policy_out   =
    ctl_reg[2][asrc_pkg::C2_POLICY_HI:asrc_pkg::C2_POLICY_LO];
  assign recovered_clock_ratio_out = ctl_reg[2][asrc_pkg::C2_CLOCK_RATIO];
  assign receiver_mono_out         = ctl_reg[2][asrc_pkg::C2_RX_MONO];
  assign transmitter_mono_out      = ctl_reg[2][asrc_pkg::C2_TX_MONO];
  assign data_routing_out          = ctl_reg[3];
  assign clock_routing_out         = ctl_reg[4];
  assign serial_input_format_out   = ctl_reg[5];
  assign serial_output_format_out  = ctl_reg[6];
  assign receive_error_mask_out    = ctl_reg[17];
  assign status_buffer_control_out = ctl_reg[18];
  assign user_buffer_control_out   = ctl_reg[19];

endmodule : asrc_reg_bank

`default_nettype wire

// File: tb/asrc_host_model.sv
/* Host model: issues pointer, write and read byte strobes.
   Assumes the bench calls xfer; it drives on falling edges. */
`default_nettype none
module asrc_host_model (
  input  wire logic       mclk_in,
  output logic            ptr_wr_out, data_wr_out, data_rd_out,
  output logic      [7:0] byte_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {ptr_wr_out, data_wr_out, data_rd_out, byte_out} = '0;
  // One strobe for one cycle; byte inverted after, so stale data never helps
  task automatic xfer(input logic [2:0] kind, input logic [7:0] b);
    @(negedge mclk_in);
    {ptr_wr_out, data_wr_out, data_rd_out} = kind;
    byte_out = b;
    @(negedge mclk_in);
    {ptr_wr_out, data_wr_out, data_rd_out} = 3'h0;
    byte_out = ~b;
  endtask : xfer
endmodule : asrc_host_model
`default_nettype wire

// File: tb/asrc_reg_bank_asserts.sv
/* Port checker for the register bank.
   Assumes a bind into asrc_reg_bank and one clock domain. */
`default_nettype none
module asrc_reg_bank_asserts (
  input wire logic       mclk_in, rstn_in, ce_in, ptr_wr_in, data_wr_in, data_rd_in,
  input wire logic [7:0] wr_byte_in, pointer_out,
  input wire logic       rd_valid_out, rx_no_input_in, recovered_master_clock_pin_from_output_master_clock_out,
  input wire logic       validity_level_out, serial_out_mute_out, line_tx_mute_out,
  input wire logic       block_sync_direction_out, length_from_status_out,
  input wire logic [1:0] error_sample_policy_out,
  input wire logic       recovered_clock_ratio_out, receiver_mono_out,
  input wire logic       transmitter_mono_out, tx_sub_a_right_out, tx_sub_b_right_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  logic dat, wr1, wr2;  // Accepted data byte, writes to slots 1 and 2
  assign dat = ce_in && !ptr_wr_in && (data_wr_in || data_rd_in);
  assign wr1 = dat && data_wr_in && pointer_out[6:0] == 7'h01;
  assign wr2 = dat && data_wr_in && pointer_out[6:0] == 7'h02;
  ptr_load_a: assert property (ce_in && ptr_wr_in |=> pointer_out == $past(wr_byte_in))
    else $error("pointer load wrong");
  ptr_hold_a: assert property (dat && !pointer_out[7] |=> $stable(pointer_out))
    else $error("pointer moved");
  ptr_step_a: assert property (dat && pointer_out[7] |=>
    pointer_out == {1'b1, $past(pointer_out[6:0]) + 7'h01}) else $error("pointer step wrong");
  read_pulse_a: assert property (dat && !data_wr_in |=> rd_valid_out)
    else $error("no read answer");
  ctl_one_a: assert property (wr1 |=> {validity_level_out, serial_out_mute_out,
    line_tx_mute_out, block_sync_direction_out} == {$past(wr_byte_in[6:4]), $past(wr_byte_in[0])})
    else $error("control one bits wrong");
  ctl_two_a: assert property (wr2 |=> {length_from_status_out, error_sample_policy_out,
    recovered_clock_ratio_out, receiver_mono_out, transmitter_mono_out} == $past(wr_byte_in[7:2]))
    else $error("control two bits wrong");
  clk_subst_a: assert property (!$past(rx_no_input_in) |-> !recovered_master_clock_pin_from_output_master_clock_out)
    else $error("clock substituted with input present");
  mono_slot_a: assert property (tx_sub_a_right_out |-> tx_sub_b_right_out)
    else $error("slot sources split");
endmodule : asrc_reg_bank_asserts
bind asrc_reg_bank asrc_reg_bank_asserts u_chk (.*);
`default_nettype wire

// File: tb/asrc_reg_bank_tb_top.sv
/* Bench for the register bank: host model drives strobes, monitor checks reads.
   Assumes a 50 MHz clock and synchronous active-low reset. */
`default_nettype none
module asrc_reg_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] ID = 4'h9, VER = 4'h3;  // Arbitrary values
  logic mclk_in = 0, rstn_in = 0, ce_in = 1, alert_pin_in = 0, rx_no_input_in = 1;
  logic ptr_wr_in, data_wr_in, data_rd_in, rd_valid_out, alert_pin_out, alert_pin_oe_out;
  logic recovered_master_clock_pin_from_output_master_clock_out, validity_level_out, serial_out_mute_out, line_tx_mute_out;
  logic dither_enable_out, block_sync_direction_out, length_from_status_out;
  logic recovered_clock_ratio_out, receiver_mono_out, transmitter_mono_out;
  logic tx_sub_a_right_out, tx_sub_b_right_out, tx_status_a_right_out, tx_status_b_right_out;
  logic [7:0] wr_byte_in, rd_byte_out, pointer_out, received_summary_in, receive_errors_in;
  logic [7:0] rate_ratio_in, data_routing_out, clock_routing_out, serial_input_format_out;
  logic [7:0] serial_output_format_out, receive_error_mask_out, status_buffer_control_out;
  logic [7:0] user_buffer_control_out, r1, r2, ra[6], re[6], expq[$];
  logic [1:0] error_sample_policy_out;
  logic [15:0] event_src_in = '0;
  logic [79:0] subcode_in;
  int error_cnt = 0, comparisons = 0, cyc = 0, seed = 32'ha897;
  always #10 mclk_in = ~mclk_in;
  asrc_host_model host (.mclk_in, .ptr_wr_out(ptr_wr_in), .data_wr_out(data_wr_in),
    .data_rd_out(data_rd_in), .byte_out(wr_byte_in));
  asrc_reg_bank #(.IDENTITY_CODE(ID), .VERSION_CODE(VER)) dut (.*);
  task automatic test_done;
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(3'h4, a);
    host.xfer(3'h2, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.xfer(3'h4, a);
    expq.push_back(e);
    host.xfer(3'h1, 8'h00);
  endtask : rd
  // Read monitor: oldest note against each answer
  always @(negedge mclk_in) if (rd_valid_out === 1'b1) chk("read", expq.pop_front(), rd_byte_out);
  always @(posedge mclk_in) if (++cyc == 3000) begin
    error_cnt++;
    test_done();
  end
  initial begin
    {received_summary_in, receive_errors_in, rate_ratio_in} = 24'($random(seed));
    subcode_in = 80'({$random(seed), $random(seed), $random(seed)});
    r1 = 8'($random(seed)) & 8'hf9;  // Alert code 00 kept for the event test
    r2 = 8'($random(seed)) & 8'hdf;  // Reserved error policy avoided
    repeat (8) @(negedge mclk_in);
    rstn_in = 1;
    chk("pointer", 8'h01, pointer_out);
    host.xfer(3'h4, 8'h81);
    host.xfer(3'h2, r1);
    host.xfer(3'h2, r2);
    chk("pointer", 8'h83, pointer_out);
    rd(8'h01, r1);
    expq.push_back(r1);  // Noted before the strobe, so the monitor never races it
    host.xfer(3'h1, 8'h00);  // Fixed pointer: same slot again
    chk("pointer", 8'h01, pointer_out);
    chk("dither", 8'(!r1[3]), 8'(dither_enable_out));
    chk("slot", 8'(r2[2] & r2[0]), 8'(tx_sub_a_right_out));
    ra = '{8'h7f, 8'h1e, 8'h14, 8'h1f, 8'h00, 8'h02};
    re = '{{ID, VER}, rate_ratio_in, subcode_in[7:0], 8'h00, 8'h00, r2};
    foreach (ra[i]) rd(ra[i], re[i]);
    wr(8'h09, 8'h01);
    event_src_in = 16'h0003;  // Source 1 rises too but stays masked
    repeat (2) @(negedge mclk_in);
    chk("alert", 8'h01, 8'(alert_pin_out));
    rd(8'h07, 8'h01);
    rd(8'h07, 8'h00);
    chk("alert", 8'h00, 8'(alert_pin_out));
    wr(8'h0a, 8'h01);  // Level mode while source high
    rd(8'h07, 8'h01);
    rd(8'h07, 8'h01);
    wr(8'h0a, 8'h00);
    wr(8'h0b, 8'h01);  // Falling mode
    rd(8'h07, 8'h01);
    rd(8'h07, 8'h00);
    event_src_in = 16'h0000;
    rd(8'h07, 8'h01);
    for (int c = 0; c < 4; c++) begin
      rx_no_input_in = c[0];
      wr(8'h01, {5'h0, c[1:0], 1'b0});
      repeat (2) @(negedge mclk_in);
      chk("alert", (c == 1) ? 8'h03 : 8'(c == 0), {6'h0, alert_pin_out & (c != 3), alert_pin_oe_out});
    end
    repeat (4) @(negedge mclk_in);
    test_done();
  end
endmodule : asrc_reg_bank_tb_top
`default_nettype wire
